// ### design/rx_irq_regs.svh
`ifndef RX_IRQ_REGS_SVH
`define RX_IRQ_REGS_SVH

// Register addresses on the device register port.
`define ADDR_CONFIG        8'h05
`define ADDR_BYTE_SER_CTL  8'h06
`define ADDR_RX_INT_EN     8'h07
`define ADDR_RX_STATUS     8'h08
`define ADDR_RX_DATA_A     8'h09
`define ADDR_RX_DATA_B     8'h0b

// Reset values.
`define RST_CONFIG         8'h01
`define RST_BYTE_SER_CTL   8'h03
`define RST_RX_INT_EN      8'h00
`define RST_RX_DATA        8'h00

// Field positions.
`define CFG_IRQ_SEL_MSB    1
`define CFG_IRQ_SEL_LSB    0
`define CTL_EOF_LEN_MSB    2
`define CTL_EOF_LEN_LSB    0
`define CHAN_NIBBLE_W      4
`define BIT_FULL           0
`define BIT_EOF            1
`define BIT_OVERFLOW       2
`define BIT_UNDERFLOW      3
`define BIT_FLOW           2
`define BIT_VALID          3

// Interrupt pin drive styles.
`define IRQ_OPEN_DRAIN     2'h3
`define IRQ_OPEN_SOURCE    2'h2
`define IRQ_PUSH_HIGH      2'h1
`define IRQ_PUSH_LOW       2'h0

// Last bit index of a byte.
`define BYTE_LAST_BIT      3'h7

`endif

// ### design/rx_irq_pkg.sv
`default_nettype none

package rx_irq_pkg;

   // Per-channel receive state of the byte_serializer.
   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [3:0] gap_cnt;
      logic       started;
      logic [7:0] data;
      logic       has_data;
      logic       all_valid;
      logic       full;
      logic       overflow;
      logic       underflow;
      logic       eof;
   } chan_state_t;

   // Receiver strobes for one channel.
   typedef struct packed {
      logic tick;
      logic valid;
      logic value;
   } rx_bit_t;

endpackage

`default_nettype wire

// ### design/dual_rx_byte_serializer_irq_enable.sv
`include "rx_irq_regs.svh"
`default_nettype none

// Contract
// - Bit 7 gates channel B underflow interrupt.
// - Bit 6 gates channel B overflow interrupt.
// - Bit 5 gates channel B end-of-frame interrupt.
// - Bit 4 gates channel B full interrupt.
// - Bit 3 gates channel A underflow interrupt.
// - Bit 2 gates channel A overflow interrupt.
// - Bit 1 gates channel A end-of-frame interrupt.
// - Bit 0 gates channel A full interrupt.
// - Reading empty data register flags underflow.
// - Loading unread data register flags overflow.
// - End of frame when gap exceeds length.
// - Length zero ends at first invalid bit.
// - Status read clears end-of-frame flags.
// - Every transfer into data register flags full.
// - Flags set regardless of enable bits.
// - Three-bit gap length in control bits 2:0.
// - Two-bit setting selects interrupt pin style.
// - Status read clears flow violation flags.
module dual_rx_byte_serializer_irq_enable
(
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   input  wire logic                  rx_enable,
   input  wire rx_irq_pkg::rx_bit_t   rx_bit_a,
   input  wire rx_irq_pkg::rx_bit_t   rx_bit_b,
   output logic                       irq_out,
   output logic                       irq_oe
);

   function automatic logic [7:0] data_addr(input int ch);
      data_addr = (ch == 0) ? `ADDR_RX_DATA_A : `ADDR_RX_DATA_B;
   endfunction

   logic [7:0]            config_reg;
   logic [7:0]            config_next;
   logic [7:0]            ser_ctl_reg;
   logic [7:0]            ser_ctl_next;
   logic [7:0]            int_en_reg;
   logic [7:0]            int_en_next;
   logic [7:0]            rdata_reg;
   logic [7:0]            rdata_next;
   logic                  irq_out_reg;
   logic                  irq_out_next;
   logic                  irq_oe_reg;
   logic                  irq_oe_next;
   logic [2:0]            eof_len;
   logic                  status_rd;
   logic                  irq_req;
   logic [7:0]            status_bits;
   logic [7:0]            pending;
   rx_irq_pkg::rx_bit_t   rx_bit [2];
   rx_irq_pkg::chan_state_t chan_cur [2];

   assign rx_bit[0] = rx_bit_a;
   assign rx_bit[1] = rx_bit_b;

   assign eof_len   = ser_ctl_reg[`CTL_EOF_LEN_MSB:`CTL_EOF_LEN_LSB];
   assign status_rd = reg_rd && (reg_addr == `ADDR_RX_STATUS);

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_chan
         rx_irq_pkg::chan_state_t cur;
         rx_irq_pkg::chan_state_t nxt;
         logic                    load;
         logic                    load_whole;
         logic                    data_rd;
         logic [3:0]              gap_inc;

         assign chan_cur[ch] = cur;

         always_comb
         begin
            nxt        = cur;
            load       = 1'b0;
            load_whole = 1'b0;
            gap_inc    = cur.gap_cnt + 4'h1;
            data_rd    = reg_rd && (reg_addr == data_addr(ch));

            // Clears come first so that a same-cycle event wins.
            // status read clear
            if (status_rd)
            begin
               nxt.eof       = 1'b0;
               nxt.overflow  = 1'b0;
               nxt.underflow = 1'b0;
            end

            if (data_rd)
            begin
               if (!cur.has_data)
                  nxt.underflow = 1'b1;
               nxt.has_data = 1'b0;
               nxt.full     = 1'b0;
            end

            if (rx_bit[ch].tick)
            begin
               if (rx_bit[ch].valid)
               begin
                  nxt.shift   = {cur.shift[6:0], rx_bit[ch].value};
                  nxt.started = 1'b1;
                  nxt.gap_cnt = 4'h0;
                  nxt.bit_cnt = cur.bit_cnt + 3'h1;
                  if (cur.bit_cnt == `BYTE_LAST_BIT)
                  begin
                     load       = 1'b1;
                     load_whole = 1'b1;
                     // The shifter restarts empty so a short byte is zero-filled.
                     nxt.shift  = 8'h00;
                  end
               end
               else if (cur.started)
               begin
                  nxt.gap_cnt = gap_inc;
                  if (gap_inc > {1'b0, eof_len})
                  begin
                     nxt.eof     = 1'b1;
                     nxt.started = 1'b0;
                     nxt.shift   = 8'h00;
                     nxt.gap_cnt = 4'h0;
                     nxt.bit_cnt = 3'h0;
                     // A partial byte is pushed out at end of frame.
                     if (cur.bit_cnt != 3'h0)
                        load = 1'b1;
                  end
               end
            end

            if (load)
            begin
               if (cur.has_data && !data_rd)
                  nxt.overflow = 1'b1;
               nxt.data      = load_whole ?
                               {cur.shift[6:0], rx_bit[ch].value} :
                               cur.shift;
               nxt.has_data  = 1'b1;
               nxt.full      = 1'b1;
               nxt.all_valid = load_whole;
            end
         end

         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
               cur <= '0;
            else
               cur <= nxt;
         end

         assign status_bits[ch*4 +: 4] =
            {cur.all_valid, cur.overflow | cur.underflow,
             cur.eof, cur.full};
      end
   endgenerate

   assign pending[7] = int_en_reg[7] & chan_cur[1].underflow;
   assign pending[6] = int_en_reg[6] & chan_cur[1].overflow;
   assign pending[5] = int_en_reg[5] & chan_cur[1].eof;
   assign pending[4] = int_en_reg[4] & chan_cur[1].full;
   assign pending[3] = int_en_reg[3] & chan_cur[0].underflow;
   assign pending[2] = int_en_reg[2] & chan_cur[0].overflow;
   assign pending[1] = int_en_reg[1] & chan_cur[0].eof;
   assign pending[0] = int_en_reg[0] & chan_cur[0].full;

   assign irq_req = |pending;

   always_comb
   begin
      config_next  = config_reg;
      ser_ctl_next = ser_ctl_reg;
      int_en_next  = int_en_reg;
      rdata_next   = rdata_reg;
      if (reg_wr)
      begin
         case (reg_addr)
            `ADDR_CONFIG:       config_next  = reg_wdata;
            `ADDR_BYTE_SER_CTL: ser_ctl_next = reg_wdata;
            `ADDR_RX_INT_EN:    int_en_next  = reg_wdata;
            default:            config_next  = config_reg;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            `ADDR_CONFIG:       rdata_next = config_reg;
            `ADDR_BYTE_SER_CTL: rdata_next = ser_ctl_reg;
            `ADDR_RX_INT_EN:    rdata_next = int_en_reg;
            // Status reads zero outside receive mode.
            `ADDR_RX_STATUS:    rdata_next = rx_enable ? status_bits : 8'h00;
            `ADDR_RX_DATA_A:    rdata_next = chan_cur[0].data;
            `ADDR_RX_DATA_B:    rdata_next = chan_cur[1].data;
            default:            rdata_next = 8'h00;
         endcase
      end
   end

   always_comb
   begin
      case (config_reg[`CFG_IRQ_SEL_MSB:`CFG_IRQ_SEL_LSB])
         `IRQ_OPEN_DRAIN:
         begin
            irq_out_next = 1'b0;
            irq_oe_next  = irq_req;
         end
         `IRQ_OPEN_SOURCE:
         begin
            irq_out_next = 1'b1;
            irq_oe_next  = irq_req;
         end
         `IRQ_PUSH_HIGH:
         begin
            irq_out_next = irq_req;
            irq_oe_next  = 1'b1;
         end
         default:
         begin
            irq_out_next = !irq_req;
            irq_oe_next  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         config_reg  <= `RST_CONFIG;
         ser_ctl_reg <= `RST_BYTE_SER_CTL;
         int_en_reg  <= `RST_RX_INT_EN;
         rdata_reg   <= 8'h00;
         irq_out_reg <= 1'b0;
         irq_oe_reg  <= 1'b1;
      end
      else
      begin
         config_reg  <= config_next;
         ser_ctl_reg <= ser_ctl_next;
         int_en_reg  <= int_en_next;
         rdata_reg   <= rdata_next;
         irq_out_reg <= irq_out_next;
         irq_oe_reg  <= irq_oe_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq_out   = irq_out_reg;
   assign irq_oe    = irq_oe_reg;

endmodule // dual_rx_byte_serializer_irq_enable

`default_nettype wire

// ### bench/rx_irq_properties.sv
`default_nettype none
module rx_irq_properties
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       rx_enable,
   input wire logic       irq_out,
   input wire logic       irq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] style_reg;
   logic [7:0] en_reg;
   // Shadows the pin style and enable registers from the write strobes.
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
      begin
         style_reg <= 2'h1;
         en_reg    <= 8'h00;
      end
      else if (reg_wr)
      begin
         if (reg_addr == 8'h05) style_reg <= reg_wdata[1:0];
         if (reg_addr == 8'h07) en_reg <= reg_wdata;
      end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence en_wr_s; reg_wr && reg_addr == 8'h07; endsequence
   sequence en_rd_s; reg_rd && !reg_wr && reg_addr == 8'h07; endsequence
   sequence quiet_s; $past(en_reg, 2) == 8'h00 && $past(en_reg) == 8'h00 &&
      $past(style_reg) == style_reg; endsequence
   enable_readback_a:
      assert property (en_wr_s ##2 en_rd_s |=> reg_rdata == $past(reg_wdata, 3))
      else $error("enable register read back wrong");
   unmapped_read_a:
      assert property (reg_rd && !(reg_addr inside {8'h05, 8'h06, 8'h07,
         8'h08, 8'h09, 8'h0b}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a:
      assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   rx_off_status_a:
      assert property (reg_rd && reg_addr == 8'h08 && !rx_enable
         |=> reg_rdata == 8'h00) else $error("status not zero in idle");
   drain_style_a:
      assert property ($past(style_reg) == 2'h3 && style_reg == 2'h3
         |-> !irq_out) else $error("open drain pin driven high");
   source_style_a:
      assert property ($past(style_reg) == 2'h2 && style_reg == 2'h2
         |-> irq_out) else $error("open source pin driven low");
   idle_pin_a:
      assert property (quiet_s ##0 !style_reg[1] |-> irq_out == !style_reg[0]
         && irq_oe) else $error("push pull pin asserted with no enable");
   idle_float_a:
      assert property (quiet_s ##0 style_reg[1] |-> !irq_oe)
      else $error("open pin driven with no enable");
endmodule // rx_irq_properties
bind dual_rx_byte_serializer_irq_enable rx_irq_properties chk
(
   .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .rx_enable(rx_enable), .irq_out(irq_out), .irq_oe(irq_oe)
);
`default_nettype wire

// ### bench/rx_bit_source.sv
`default_nettype none
module rx_bit_source
(
   input  wire logic          clk_sys,
   output rx_irq_pkg::rx_bit_t bit_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bit_o = '0;
   // Sends nv valid bits MSB first, then ni invalid bit times.
   task automatic send(input logic [7:0] d, input int nv, input int ni);
      for (int i = 0; i < nv + ni; i++)
      begin
         @(posedge clk_sys);
         bit_o <= '{tick: 1'b1, valid: i < nv,
                    value: (i < nv) ? d[3'(7 - i)] : ~bit_o.value};
         @(posedge clk_sys);
         bit_o <= '{tick: 1'b0, valid: 1'b0, value: ~bit_o.value};
      end
   endtask
endmodule // rx_bit_source
`default_nettype wire

// ### bench/dual_rx_byte_serializer_irq_enable_test.sv
`default_nettype none
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
   err_total++; $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
   end end
module dual_rx_byte_serializer_irq_enable_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clk_sys, reset_n, reg_wr, reg_rd, rx_enable;
   logic [7:0]          reg_addr, reg_wdata, reg_rdata;
   rx_irq_pkg::rx_bit_t rx_bit_a, rx_bit_b;
   logic                irq_out, irq_oe;
   int                  err_total = 0;
   int                  n_checks = 0;
   logic [1:0]          pin_exp [4] = '{2'b01, 2'b11, 2'b11, 2'b01};
   logic [1:0]          idle_exp [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
   // Flags left pending for the gate sweep: underflow A, end of frame A,
   // full B and overflow B.
   logic [7:0]          gate_exp = 8'h5a;
   dual_rx_byte_serializer_irq_enable DUT
   (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .rx_enable(rx_enable), .rx_bit_a(rx_bit_a),
      .rx_bit_b(rx_bit_b), .irq_out(irq_out), .irq_oe(irq_oe)
   );
   rx_bit_source src_a (.clk_sys(clk_sys), .bit_o(rx_bit_a));
   rx_bit_source src_b (.clk_sys(clk_sys), .bit_o(rx_bit_b));
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task give_verdict;
      if (err_total == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHECK(reg_rdata & m, e)
   endtask
   // The pin is registered one cycle behind the flags; three gives margin.
   task pin(input logic [1:0] e);
      repeat (3) @(posedge clk_sys);
      #1;
      `CHECK({irq_out, irq_oe}, e)
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata, reset_n} = '0;
      rx_enable = 1'b1;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(8'h05, 8'h01, 8'hff);
      rd(8'h06, 8'h03, 8'hff);
      rd(8'h07, 8'h00, 8'hff);
      rd(8'h08, 8'h00, 8'hff);
      rd(8'h20, 8'h00, 8'hff);
      wr(8'h07, 8'ha5);
      rd(8'h07, 8'ha5, 8'hff);
      wr(8'h07, 8'h00);
      pin(2'b01);
      wr(8'h06, 8'h00);
      src_a.send(8'hb4, 8, 1);
      wr(8'h07, 8'h02);
      pin(2'b11);
      rd(8'h08, 8'h03, 8'h77);
      pin(2'b01);
      rd(8'h08, 8'h01, 8'h77);
      rd(8'h09, 8'hb4, 8'hff);
      rd(8'h09, 8'h00, 8'h00);
      rd(8'h08, 8'h04, 8'h77);
      rd(8'h08, 8'h00, 8'h77);
      wr(8'h06, 8'h01);
      src_b.send(8'ha0, 3, 1);
      rd(8'h08, 8'h00, 8'h77);
      src_b.send(8'h00, 0, 1);
      rd(8'h08, 8'h30, 8'h77);
      src_b.send(8'h3c, 8, 0);
      rd(8'h08, 8'h50, 8'h77);
      src_a.send(8'h81, 8, 0);
      rd(8'h08, 8'h11, 8'h77);
      src_a.send(8'h00, 0, 2);
      rd(8'h09, 8'h81, 8'hff);
      rd(8'h09, 8'h81, 8'hff);
      src_b.send(8'h5a, 8, 0);
      for (int i = 0; i < 8; i++)
      begin
         wr(8'h07, 8'h01 << i);
         if (i < 4)
            pin({gate_exp[i], 1'b1});
         else
            pin({gate_exp[i], 1'b1});
      end
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h05, 8'(s));
         wr(8'h07, 8'h02);
         pin(pin_exp[s]);
         wr(8'h07, 8'h00);
         pin(idle_exp[s]);
      end
      wr(8'h07, 8'h00);
      pin(2'b00);
      @(posedge clk_sys);
      rx_enable <= 1'b0;
      rd(8'h08, 8'h00, 8'hff);
      rd(8'h0b, 8'h5a, 8'hff);
      rd(8'h09, 8'h81, 8'hff);
      give_verdict();
   end
endmodule // dual_rx_byte_serializer_irq_enable_test
`default_nettype wire
